//--- pkg/tmds_pkg.sv
package tmds_pkg;
  // clock and timing
  localparam int CLK_MHZ         = 250;
  localparam int EXCITE_HOLD_MS  = 20;
  localparam int EXCITE_HOLD_CYC = EXCITE_HOLD_MS * CLK_MHZ * 1000;
  localparam int SEL_STABLE_CYC  = 4;

  // operation data
  localparam int ENTRY_COUNT    = 8;
  localparam int TORQUE_MAX_PCT = 300;
  localparam int MV_PER_V       = 1000;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_GAIN       = 12'h004;
  localparam logic [11:0] ADDR_BAND       = 12'h008;
  localparam logic [11:0] ADDR_MINON      = 12'h00c;
  localparam logic [11:0] ADDR_GEAR       = 12'h010;
  localparam logic [11:0] ADDR_STATUS     = 12'h014;
  localparam logic [11:0] ADDR_ENTRY_BASE = 12'h020;

  // control register bit positions
  localparam int CTRL_AUTO_OFS_BIT = 0;
  localparam int CTRL_CAPTURE_BIT  = 1;
  localparam int CTRL_ANA_SRC_BIT  = 8;
  localparam int CTRL_ROT_BIT      = 9;

  // values after reset
  localparam logic [8:0]  GAIN_RST       = 9'h01e;
  localparam logic [15:0] OFS_RST        = 16'h0000;
  localparam logic [15:0] BAND_RST       = 16'h000a;
  localparam logic [31:0] MINON_RST      = 32'h00000000;
  localparam logic [15:0] GEAR_RST       = 16'h0001;
  localparam logic        ANA_SRC_RST    = 1'b1;
  localparam logic        ROT_RST        = 1'b0;

  // software settings
  typedef struct packed {
    logic               auto_ofs;
    logic [8:0]         gain;
    logic signed [15:0] ofs_mv;
    logic [15:0]        band;
    logic [31:0]        min_on;
    logic [15:0]        num;
    logic [15:0]        den;
  } tmds_cfg_t;

  // one stored operation data word
  typedef struct packed {
    logic [15:0] limit;
    logic [6:0]  unused;
    logic [8:0]  torque;
  } tmds_entry_t;

  // drive command towards the power stage
  typedef struct packed {
    logic signed [9:0] torque;
    logic [15:0]       limit;
    logic              excite;
  } tmds_drive_t;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_ON   = 2'b01,
    RUN_HOLD = 2'b10
  } tmds_run_t;
endpackage

//--- src/tmds_entry_mem.sv
`timescale 1ns/1ps
module tmds_entry_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic                     clk_en,
  // write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read ports
  input  wire logic [$clog2(DEPTH)-1:0] a_addr,
  output logic      [WIDTH-1:0]         a_data,
  input  wire logic [$clog2(DEPTH)-1:0] b_addr,
  output logic      [WIDTH-1:0]         b_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2) $error("tmds_entry_mem: depth below 2");

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      a_data <= '0;
      b_data <= '0;
    end else if (clk_en) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      a_data <= mem[a_addr];
      b_data <= mem[b_addr];
    end
  end
endmodule

//--- src/tmds_torque_select.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module tmds_torque_select
  import tmds_pkg::*;
#(
  parameter int HOLD_CYCLES = tmds_pkg::EXCITE_HOLD_CYC,
  parameter int STABLE      = tmds_pkg::SEL_STABLE_CYC
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // stored system settings
  input  wire logic               nv_analog_source_enable,
  input  wire logic               nv_rotation_sense,
  // host select and run
  input  wire logic               data_select_bit0,
  input  wire logic               data_select_bit1,
  input  wire logic               data_select_bit2,
  input  wire logic               run_forward_input,
  input  wire logic               run_reverse_input,
  // analog and motor feedback
  input  wire logic [8:0]         internal_torque_knob,
  input  wire logic signed [15:0] ext_analog_mv,
  input  wire logic [15:0]        motor_speed,
  input  wire logic               enc_pulse,
  input  wire logic               enc_dir,
  // outputs
  output tmds_pkg::tmds_drive_t   drive,
  output logic                    motion_flag,
  output logic                    zero_speed_flag,
  output logic                    enc_out_pulse,
  output logic                    enc_out_dir
);
  import tmds_pkg::*;

  if (HOLD_CYCLES < 1 || STABLE < 1 || STABLE > 255) $error("tmds: bad parameter");

  function automatic logic [8:0] clamp_pct(input logic signed [31:0] v);
    if (v < 0) begin
      return 9'h000;
    end else if (v > TORQUE_MAX_PCT) begin
      return 9'(TORQUE_MAX_PCT);
    end else begin
      return v[8:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // system settings applied once after reset
  logic ana_src, rot_sense, loaded;
  logic next_ana_src, next_rot_sense, next_loaded;

  always_comb begin
    next_ana_src   = ana_src;
    next_rot_sense = rot_sense;
    next_loaded    = 1'b1;
    if (!loaded) begin
      next_ana_src   = nv_analog_source_enable;
      next_rot_sense = nv_rotation_sense;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ana_src   <= ANA_SRC_RST;
      rot_sense <= ROT_RST;
      loaded    <= 1'b0;
    end else if (clk_en) begin
      ana_src   <= next_ana_src;
      rot_sense <= next_rot_sense;
      loaded    <= next_loaded;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb register file
  tmds_cfg_t          cfg, next_cfg;
  logic signed [15:0] auto_mv, next_auto_mv;
  logic [31:0]        next_prdata;
  logic               ack, next_ack, err, next_err;
  logic               is_entry, mapped, done, mem_we;
  logic [31:0]        mem_a_data, mem_b_data;
  logic [2:0]         active_sel, b_sel;
  tmds_entry_t        wentry;

  assign pready  = ack;
  assign pslverr = ack & err;

  always_comb begin
    wentry      = pwdata;
    is_entry    = paddr[11:5] == ADDR_ENTRY_BASE[11:5];
    mapped      = is_entry || paddr == ADDR_CTRL || paddr == ADDR_GAIN || paddr == ADDR_BAND
                  || paddr == ADDR_MINON || paddr == ADDR_GEAR || paddr == ADDR_STATUS;
    done        = psel & penable & ack;
    next_ack    = psel & penable & ~ack;
    next_err    = err;
    next_prdata = prdata;
    next_cfg    = cfg;
    next_auto_mv = auto_mv;
    mem_we      = 1'b0;
    if (next_ack) begin
      next_err = !mapped || (pwrite && is_entry && wentry.torque > TORQUE_MAX_PCT);
      if (!pwrite) begin
        case (paddr)
          ADDR_CTRL:   next_prdata = {22'h0, rot_sense, ana_src, 7'h0, cfg.auto_ofs};
          ADDR_GAIN:   next_prdata = {cfg.ofs_mv, 7'h0, cfg.gain};
          ADDR_BAND:   next_prdata = {16'h0, cfg.band};
          ADDR_MINON:  next_prdata = cfg.min_on;
          ADDR_GEAR:   next_prdata = {cfg.den, cfg.num};
          ADDR_STATUS: next_prdata = {6'h0, drive.torque, 9'h0, motion_flag,
                                      zero_speed_flag, drive.excite, 1'b0, active_sel};
          default:     next_prdata = is_entry ? mem_a_data : 32'h0;
        endcase
      end
    end
    if (done && pwrite && !err) begin
      case (paddr)
        ADDR_CTRL: begin
          next_cfg.auto_ofs = pwdata[CTRL_AUTO_OFS_BIT];
          if (pwdata[CTRL_CAPTURE_BIT] && cfg.auto_ofs) begin
            next_auto_mv = ext_analog_mv;
          end
        end
        ADDR_GAIN: begin
          next_cfg.gain   = clamp_pct(32'(pwdata[8:0]));
          next_cfg.ofs_mv = pwdata[31:16];
        end
        ADDR_BAND:  next_cfg.band = pwdata[15:0];
        ADDR_MINON: next_cfg.min_on = pwdata;
        ADDR_GEAR: begin
          next_cfg.num = pwdata[15:0];
          next_cfg.den = pwdata[31:16];
        end
        default:    mem_we = is_entry;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg     <= '{auto_ofs: 1'b0, gain: GAIN_RST, ofs_mv: OFS_RST, band: BAND_RST,
                   min_on: MINON_RST, num: GEAR_RST, den: GEAR_RST};
      auto_mv <= OFS_RST;
      ack     <= 1'b0;
      err     <= 1'b0;
      prdata  <= 32'h0;
    end else if (clk_en) begin
      cfg     <= next_cfg;
      auto_mv <= next_auto_mv;
      ack     <= next_ack;
      err     <= next_err;
      prdata  <= next_prdata;
    end
  end

  tmds_entry_mem #(
    .DEPTH (ENTRY_COUNT),
    .WIDTH (32)
  ) u_mem (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .we      (mem_we),
    .waddr   (paddr[4:2]),
    .wdata   (pwdata),
    .a_addr  (paddr[4:2]),
    .a_data  (mem_a_data),
    .b_addr  (active_sel),
    .b_data  (mem_b_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // entry select with stability filter
  logic [2:0] sel_raw, sel_now, next_sel_raw, next_active_sel;
  logic [7:0] stab_cnt, next_stab_cnt;

  always_comb begin
    sel_now         = {data_select_bit2, data_select_bit1, data_select_bit0};
    next_sel_raw    = sel_now;
    next_stab_cnt   = stab_cnt;
    next_active_sel = active_sel;
    if (sel_now != sel_raw) begin
      next_stab_cnt = 8'h00;
    end else if (stab_cnt < 8'(STABLE - 1)) begin
      next_stab_cnt = stab_cnt + 8'h01;
    end else begin
      next_active_sel = sel_raw;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_raw    <= 3'h0;
      stab_cnt   <= 8'h00;
      active_sel <= 3'h0;
      b_sel      <= 3'h0;
    end else if (clk_en) begin
      sel_raw    <= next_sel_raw;
      stab_cnt   <= next_stab_cnt;
      active_sel <= next_active_sel;
      b_sel      <= active_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // torque source, run sequence and motion output
  tmds_run_t          run_st, next_run_st;
  tmds_drive_t        next_drive;
  tmds_entry_t        cur;
  logic [31:0]        hold_cnt, next_hold_cnt, mon_cnt, next_mon_cnt;
  logic               run_req, negate, over, next_motion, next_zero;
  logic signed [15:0] ofs_sel;
  logic signed [31:0] ana_pct;
  logic [8:0]         mag;

  always_comb begin
    cur     = mem_b_data;
    ofs_sel = cfg.auto_ofs ? auto_mv : cfg.ofs_mv;
    ana_pct = ((32'(ext_analog_mv) - 32'(ofs_sel)) * $signed(32'(cfg.gain))) / MV_PER_V;
    if (ana_src && b_sel == 3'h0) begin
      mag = clamp_pct(32'(internal_torque_knob));
    end else if (ana_src && b_sel == 3'h1) begin
      mag = clamp_pct(ana_pct);
    end else begin
      mag = cur.torque;
    end
    run_req       = run_forward_input ^ run_reverse_input;
    negate        = run_reverse_input ^ rot_sense;
    over          = motor_speed > cur.limit;
    next_run_st   = run_st;
    next_hold_cnt = hold_cnt;
    next_drive    = '{torque: 10'sh000, limit: cur.limit, excite: 1'b0};
    case (run_st)
      RUN_IDLE: begin
        if (run_req) begin
          next_run_st = RUN_ON;
        end
      end
      RUN_ON: begin
        if (!run_req) begin
          next_run_st   = RUN_HOLD;
          next_hold_cnt = 32'(HOLD_CYCLES);
        end
      end
      RUN_HOLD: begin
        if (run_req) begin
          next_run_st = RUN_ON;
        end else if (hold_cnt <= 32'h1) begin
          next_run_st = RUN_IDLE;
        end else begin
          next_hold_cnt = hold_cnt - 32'h1;
        end
      end
      default: next_run_st = RUN_IDLE;
    endcase
    if (next_run_st == RUN_ON) begin
      next_drive.excite = 1'b1;
      if (!over) begin
        next_drive.torque = negate ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
      end
    end else if (next_run_st == RUN_HOLD) begin
      next_drive.excite = 1'b1;
    end
    next_zero    = motor_speed <= cfg.band;
    next_mon_cnt = (run_st == RUN_ON && !zero_speed_flag) ? cfg.min_on :
                   (mon_cnt != 32'h0 ? mon_cnt - 32'h1 : 32'h0);
    next_motion  = (run_st == RUN_ON && !zero_speed_flag) || mon_cnt != 32'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_st          <= RUN_IDLE;
      hold_cnt        <= 32'h0;
      mon_cnt         <= 32'h0;
      drive           <= '0;
      motion_flag     <= 1'b0;
      zero_speed_flag <= 1'b1;
    end else if (clk_en) begin
      run_st          <= next_run_st;
      hold_cnt        <= next_hold_cnt;
      mon_cnt         <= next_mon_cnt;
      drive           <= next_drive;
      motion_flag     <= next_motion;
      zero_speed_flag <= next_zero;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // encoder output gear
  logic [16:0] acc, next_acc, sum;
  logic        next_enc_pulse;

  always_comb begin
    sum            = acc + (enc_pulse ? {1'b0, cfg.num} : 17'h0);
    next_acc       = sum;
    next_enc_pulse = 1'b0;
    if (cfg.den != 16'h0 && sum >= {1'b0, cfg.den}) begin
      next_acc       = sum - {1'b0, cfg.den};
      next_enc_pulse = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc           <= 17'h0;
      enc_out_pulse <= 1'b0;
      enc_out_dir   <= 1'b0;
    end else if (clk_en) begin
      acc           <= next_acc;
      enc_out_pulse <= next_enc_pulse;
      enc_out_dir   <= enc_dir;
    end
  end
endmodule

//--- tb/tmds_sva.sv
`timescale 1ns/1ps
module tmds_sva #(
  parameter int HOLD_CYCLES = 50
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  clk_en,
  // apb handshake
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // host and feedback
  input wire logic                  run_forward_input,
  input wire logic                  run_reverse_input,
  input wire logic [15:0]           motor_speed,
  input wire logic                  enc_dir,
  // outputs
  input wire tmds_pkg::tmds_drive_t drive,
  input wire logic                  zero_speed_flag,
  input wire logic                  enc_out_dir
);
  import tmds_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic        one_run;
  logic        ran;
  logic        next_ran;
  logic [31:0] idle_cnt;
  logic [31:0] next_idle_cnt;
  assign one_run = run_forward_input ^ run_reverse_input;
  ////////////////////////////////////////////////////////////////////////
  // cycles since the last single run input
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_ran = ran;
    if (clk_en && one_run) begin
      next_idle_cnt = 32'h0;
      next_ran = 1'b1;
    end else if (clk_en && idle_cnt < HOLD_CYCLES + 8) begin
      next_idle_cnt = idle_cnt + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= 32'h0;
      ran <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      ran <= next_ran;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_access;
    psel && penable && clk_en;
  endsequence
  a_apb_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_run_excites: assert property (clk_en && one_run |=> drive.excite)
    else $error("single run input did not excite");
  a_idle_no_torque: assert property (clk_en && !one_run |=> drive.torque == 10'sh000)
    else $error("torque not zero without single run");
  a_hold_excite: assert property (ran && idle_cnt inside {[1:HOLD_CYCLES-2]} |-> drive.excite)
    else $error("excitation dropped early");
  a_hold_ends: assert property (idle_cnt > HOLD_CYCLES + 2 |-> !drive.excite)
    else $error("excitation held too long");
  a_torque_range: assert property (drive.torque <= 10'sh12c && drive.torque >= -10'sh12c)
    else $error("torque outside range");
  a_torque_excite: assert property (drive.torque != 10'sh000 |-> drive.excite)
    else $error("torque without excitation");
  a_zero_speed: assert property (clk_en && motor_speed == 16'h0000 |=> zero_speed_flag)
    else $error("zero speed flag missing");
  a_enc_dir: assert property (clk_en && rst_b |=> enc_out_dir == $past(enc_dir))
    else $error("encoder direction not passed");
endmodule
bind tmds_torque_select tmds_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_sva (
  .sys_clk, .rst_b, .clk_en, .psel, .penable, .pready, .pslverr,
  .run_forward_input, .run_reverse_input, .motor_speed, .enc_dir,
  .drive, .zero_speed_flag, .enc_out_dir
);

//--- tb/tmds_host.sv
`timescale 1ns/1ps
module tmds_host (
  // clock
  input  wire logic       sys_clk,
  // commands
  input  wire logic [2:0] want_sel,
  input  wire logic [1:0] want_run,
  input  wire logic       skew,
  // pins
  output logic            data_select_bit0,
  output logic            data_select_bit1,
  output logic            data_select_bit2,
  output logic            run_forward_input,
  output logic            run_reverse_input
);
  logic [2:0] sel_q = 3'h0;
  logic [2:0] pin_sel = 3'h0;
  logic [1:0] pin_run = 2'h0;
  // a slow host moves the upper select bits one cycle late
  always @(posedge sys_clk) begin
    sel_q <= want_sel;
    pin_sel <= skew ? {sel_q[2:1], want_sel[0]} : want_sel;
    pin_run <= want_run;
  end
  assign {data_select_bit2, data_select_bit1, data_select_bit0} = pin_sel;
  assign {run_reverse_input, run_forward_input} = pin_run;
endmodule

//--- tb/test_torque_mode_data_select.sv
`timescale 1ns/1ps
module test_torque_mode_data_select;
  import tmds_pkg::*;
  localparam int HOLD = 50;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               nv_ana = 1'b1;
  logic               nv_rot = 1'b0;
  logic [2:0]         want_sel = 3'h0;
  logic [1:0]         want_run = 2'h0;
  logic               skew = 1'b0;
  logic               sb0, sb1, sb2, fwd, speed_limit_entry;
  logic [8:0]         knob = 9'h000;
  logic signed [15:0] mv = 16'sh0000;
  logic [15:0]        speed = 16'h0000;
  logic               enc_p = 1'b0;
  logic               enc_d = 1'b0;
  tmds_drive_t        drive;
  logic               motion, zflag, enc_op, enc_od;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  int                 n_pulse = 0;
  logic [31:0]        lfsr = 32'h33fa;
  logic [31:0]        g = 32'h0;
  logic               ana_on = 1'b1;
  logic               rot_on = 1'b0;
  logic [8:0]         tq [8];
  logic [15:0]        lim [8];
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (enc_op === 1'b1) n_pulse <= n_pulse + 1;
  tmds_host i_host (.sys_clk, .want_sel, .want_run, .skew, .data_select_bit0(sb0),
    .data_select_bit1(sb1), .data_select_bit2(sb2), .run_forward_input(fwd),
    .run_reverse_input(speed_limit_entry));
  tmds_torque_select #(.HOLD_CYCLES(HOLD), .STABLE(4)) i_dut (.sys_clk, .rst_b,
    .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nv_analog_source_enable(nv_ana), .nv_rotation_sense(nv_rot), .data_select_bit0(sb0),
    .data_select_bit1(sb1), .data_select_bit2(sb2), .run_forward_input(fwd),
    .run_reverse_input(speed_limit_entry), .internal_torque_knob(knob), .ext_analog_mv(mv),
    .motor_speed(speed), .enc_pulse(enc_p), .enc_dir(enc_d), .drive, .motion_flag(motion),
    .zero_speed_flag(zflag), .enc_out_pulse(enc_op), .enc_out_dir(enc_od));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [9:0] exp_ana(int v);
    int t = (v - MV_PER_V) * int'(g) / MV_PER_V;
    return (t < 0) ? 10'h000 : (t > TORQUE_MAX_PCT) ? 10'h12c : t[9:0];
  endfunction
  function automatic logic [9:0] exp_tq(int s, logic neg);
    logic [9:0] m = (ana_on && s == 0) ? {1'b0, knob} :
                    (ana_on && s == 1) ? exp_ana(5000) : {1'b0, tq[s]};
    return (neg ^ rot_on) ? -m : m;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] x, input string m);
    check_count++;
    if (got !== x) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, x, "read data");
    cmp({31'h0, e}, {31'h0, xe}, "read error");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp({31'h0, e}, {31'h0, xe}, "write error");
  endtask
  task automatic dchk(input logic [9:0] x);
    repeat (12) @(posedge sys_clk);
    cmp({22'h0, drive.torque}, {22'h0, x}, "torque");
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    int i;
    int s;
    int cnt;
    logic neg;
    logic [31:0] r;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_GAIN, {OFS_RST, 7'h0, GAIN_RST}, 1'b0);
    rd(ADDR_BAND, {16'h0, BAND_RST}, 1'b0);
    rd(ADDR_GEAR, {GEAR_RST, GEAR_RST}, 1'b0);
    rd(ADDR_MINON, MINON_RST, 1'b0);
    nv_ana <= 1'b0;
    rd(ADDR_CTRL, 32'h100, 1'b0);
    rd(12'hffc, 32'h0, 1'b1);
    wr(ADDR_ENTRY_BASE, 32'h12d, 1'b1);
    rd(ADDR_ENTRY_BASE, 32'h0, 1'b0);
    done("registers");
    g = rnd() % 301;
    wr(ADDR_GAIN, g, 1'b0);
    wr(ADDR_CTRL, 32'h1, 1'b0);
    mv <= 16'sh03e8;
    wr(ADDR_CTRL, 32'h3, 1'b0);
    mv <= 16'sh1388;
    knob <= 9'(rnd() % 301);
    for (i = 0; i < 8; i++) begin
      r = rnd();
      tq[i] = (i == 7) ? 9'h12c : 9'(r % 301);
      lim[i] = r[31:16] & 16'h7fff | 16'h0400;
      wr(ADDR_ENTRY_BASE + 12'(4 * i), {lim[i], 7'h0, tq[i]}, 1'b0);
    end
    for (i = 0; i < 16; i++) begin
      r = rnd();
      s = (i < 8) ? i : int'(r[6:4]);
      neg = (i >= 8) && r[0];
      skew <= i[0];
      want_sel <= s[2:0];
      want_run <= neg ? 2'b10 : 2'b01;
      dchk(exp_tq(s, neg));
      cmp({16'h0, drive.limit}, {16'h0, lim[s]}, "limit");
    end
    done("entries");
    speed <= lim[s] + 16'h1;
    dchk(10'h000);
    speed <= lim[s];
    dchk(exp_tq(s, neg));
    speed <= 16'h0;
    want_run <= 2'b11;
    dchk(10'h000);
    want_run <= 2'b00;
    dchk(10'h000);
    repeat (HOLD) @(posedge sys_clk);
    cmp({31'h0, drive.excite}, 32'h0, "excite");
    done("run");
    want_sel <= 3'h1;
    want_run <= 2'b01;
    mv <= 16'sh4e20;
    dchk(exp_ana(20000));
    mv <= 16'shf448;
    dchk(10'h000);
    done("clamp");
    wr(ADDR_BAND, 32'h64, 1'b0);
    speed <= 16'h0064;
    repeat (6) @(posedge sys_clk);
    cmp({31'h0, zflag}, 32'h1, "zero speed");
    speed <= 16'h0065;
    repeat (6) @(posedge sys_clk);
    cmp({31'h0, zflag}, 32'h0, "zero speed");
    wr(ADDR_MINON, 32'h28, 1'b0);
    speed <= 16'h01f4;
    repeat (6) @(posedge sys_clk);
    speed <= 16'h0;
    want_run <= 2'b00;
    cnt = 0;
    repeat (100) begin
      @(posedge sys_clk);
      if (motion === 1'b1) cnt++;
    end
    cmp({31'h0, cnt >= 38}, 32'h1, "motion on time");
    cmp({31'h0, motion}, 32'h0, "motion off");
    done("flags");
    wr(ADDR_GEAR, 32'h00030002, 1'b0);
    cnt = n_pulse;
    repeat (6) begin
      @(posedge sys_clk);
      enc_p <= 1'b1;
      enc_d <= rnd() > 32'h7fffffff;
      @(posedge sys_clk);
      enc_p <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    cmp(32'(n_pulse - cnt), 32'h4, "encoder pulses");
    done("encoder");
    nv_rot <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    ana_on = 1'b0;
    rot_on = 1'b1;
    rd(ADDR_CTRL, 32'h200, 1'b0);
    for (i = 0; i < 2; i++) begin
      wr(ADDR_ENTRY_BASE + 12'(4 * i), {lim[i], 7'h0, tq[i]}, 1'b0);
      want_sel <= i[2:0];
      want_run <= 2'b01;
      dchk(exp_tq(i, 1'b0));
    end
    done("power cycle");
    wrap_up();
  end
endmodule
